// ==== hw/dac_serial_load_control.sv ====
`timescale 1ns/1ps
`include "dac_serial_defines.svh"

// Overview of operation
// R1: reset pin low returns every register to its power-on state; the pin filters and edge history reset only with the system.
// R2: clear low loads the preset code into the converter and updates output.
// R3: cleared output follows the currently selected coding, binary or twos.
// R4: load strobe low at frame end updates converter on frame rising edge.
// R5: load strobe high through frame: only input register; update on its fall.
// R6: host always drives the load strobe to a defined level.
// R7: 24-bit shift register samples write data on serial clock falling edges.
// R8: readback data changes on serial clock rising edges.
// R9: host keeps serial clock at or below 35 MHz when writing.
// R10: shift only while frame select low, on falls after its falling edge.
// R11: host holds frame select low for the whole transfer.
// R12: host keeps serial clock at or below 16 MHz when reading back.
// R13: readback line released once frame select returns high.
// R14: frame end acts on last 24 bits; shorter frames are ignored.
module dac_serial_load_control (
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire logic I_SCLK,
	input wire logic I_FRAME_SEL_N,
	input wire logic I_SERIAL_WRITE_IN,
	input wire logic I_OUTPUT_LOAD_STROBE_N,
	input wire logic I_CLEAR_TO_PRESET_N,
	input wire logic I_DEVICE_RESET_N,
	input wire logic [`DSL_WORD_BITS-1:0] I_CLEAR_CODE,
	input wire logic I_CODING_TWOS,
	input wire logic [`DSL_WORD_BITS-1:0] I_READBACK_WORD,
	output logic O_SERIAL_READBACK_OUT,
	output logic O_SERIAL_READBACK_OE,
	output logic [`DSL_WORD_BITS-1:0] O_INPUT_WORD,
	output logic [`DSL_WORD_BITS-1:0] O_CONVERTER_WORD,
	output logic O_CONVERTER_TWOS,
	output logic O_OUTPUT_UPDATE,
	output logic O_INPUT_UPDATE
);
	logic [`DSL_PIN_COUNT-1:0] pins;
	logic [`DSL_PIN_COUNT-1:0] lvl;
	logic [`DSL_PIN_COUNT-1:0] lvl_d;
	logic sclk_fall;
	logic sclk_rise;
	logic frame_open;
	logic frame_close;
	logic load_fall;
	dac_serial_pkg::frame_state_t state;
	dac_serial_pkg::frame_state_t next_state;
	logic [`DSL_WORD_BITS-1:0] shift_in;
	logic [`DSL_WORD_BITS-1:0] next_shift_in;
	logic [`DSL_WORD_BITS-1:0] shift_out;
	logic [`DSL_WORD_BITS-1:0] next_shift_out;
	logic [`DSL_CNT_BITS-1:0] bit_cnt;
	logic [`DSL_CNT_BITS-1:0] next_bit_cnt;
	logic rb_out;
	logic next_rb_out;
	logic rb_oe;
	logic next_rb_oe;
	logic [`DSL_WORD_BITS-1:0] input_word;
	logic [`DSL_WORD_BITS-1:0] next_input_word;
	logic [`DSL_WORD_BITS-1:0] conv_word;
	logic [`DSL_WORD_BITS-1:0] next_conv_word;
	logic conv_twos;
	logic next_conv_twos;
	logic out_upd;
	logic next_out_upd;
	logic in_upd;
	logic next_in_upd;
	logic clear_busy;
	logic next_clear_busy;

	// every pin comes from the host's domain, so all of them are synchronised
	assign pins[`DSL_PIN_SCLK] = I_SCLK;
	assign pins[`DSL_PIN_FRAME] = I_FRAME_SEL_N;
	assign pins[`DSL_PIN_WRITE] = I_SERIAL_WRITE_IN;
	assign pins[`DSL_PIN_LOAD] = I_OUTPUT_LOAD_STROBE_N;
	assign pins[`DSL_PIN_CLEAR] = I_CLEAR_TO_PRESET_N;
	assign pins[`DSL_PIN_RESET] = I_DEVICE_RESET_N;

	pin_sync #(
		.WIDTH(`DSL_PIN_COUNT),
		.IDLE(`DSL_PIN_IDLE)
	) u_pin_sync (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_pin(pins),
		.o_level(lvl)
	);

	// edge detection on the filtered levels; data and clock share latency
	// so the write bit seen at a clock fall is the one the host set up
	assign sclk_fall = lvl_d[`DSL_PIN_SCLK] & ~lvl[`DSL_PIN_SCLK];
	assign sclk_rise = ~lvl_d[`DSL_PIN_SCLK] & lvl[`DSL_PIN_SCLK];
	assign frame_open = lvl_d[`DSL_PIN_FRAME] & ~lvl[`DSL_PIN_FRAME];
	assign frame_close = ~lvl_d[`DSL_PIN_FRAME] & lvl[`DSL_PIN_FRAME];
	assign load_fall = lvl_d[`DSL_PIN_LOAD] & ~lvl[`DSL_PIN_LOAD];

	// next-state logic for the serial port and the update path
	always_comb
	begin
		next_state = state;
		next_shift_in = shift_in;
		next_shift_out = shift_out;
		next_bit_cnt = bit_cnt;
		next_rb_out = rb_out;
		next_rb_oe = rb_oe;
		next_input_word = input_word;
		next_conv_word = conv_word;
		next_conv_twos = conv_twos;
		next_out_upd = 1'b0;
		next_in_upd = 1'b0;
		next_clear_busy = 1'b0;
		case (state)
			dac_serial_pkg::ST_IDLE:
			begin
				next_rb_oe = 1'b0; // see R13
				if (frame_open)
				begin
					// shifting is enabled only from the frame's falling edge
					next_state = dac_serial_pkg::ST_FRAME; // see R10
					next_bit_cnt = '0;
					next_shift_out = I_READBACK_WORD;
					next_rb_oe = 1'b1;
				end
			end
			dac_serial_pkg::ST_FRAME:
			begin
				if (frame_close)
				begin
					next_state = dac_serial_pkg::ST_IDLE;
					next_rb_oe = 1'b0; // see R13
					// short frames are dropped; long ones keep the last 24 bits
					if (bit_cnt == `DSL_CNT_FULL) // see R14
					begin
						next_input_word = shift_in; // see R5
						next_in_upd = 1'b1;
						if (!lvl[`DSL_PIN_LOAD])
						begin
							next_conv_word = shift_in; // see R4
							next_conv_twos = I_CODING_TWOS;
							next_out_upd = 1'b1;
						end
					end
				end
				else
				begin
					if (sclk_fall)
					begin
						next_shift_in = {shift_in[`DSL_WORD_BITS-2:0],
							lvl[`DSL_PIN_WRITE]}; // see R7
						if (bit_cnt != `DSL_CNT_FULL)
						begin
							next_bit_cnt = bit_cnt + 1'b1;
						end
					end
					if (sclk_rise)
					begin
						// msb first; host samples it late in the following low phase
						next_rb_out = shift_out[`DSL_WORD_BITS-1]; // see R8
						next_shift_out = {shift_out[`DSL_WORD_BITS-2:0], 1'b0};
					end
				end
			end
			default:
			begin
				next_state = dac_serial_pkg::ST_IDLE;
				next_rb_oe = 1'b0;
			end
		endcase
		// a load strobe fall outside a frame end moves the input word across
		if (load_fall && !next_out_upd)
		begin
			next_conv_word = next_input_word; // see R5
			next_conv_twos = I_CODING_TWOS;
			next_out_upd = 1'b1;
		end
		// clear is a level: it holds the preset for as long as it is low
		// and overrides any converter update in the same cycle; the input word still loads
		if (!lvl[`DSL_PIN_CLEAR])
		begin
			next_conv_word = I_CLEAR_CODE; // see R2
			next_conv_twos = I_CODING_TWOS; // see R3
			next_clear_busy = 1'b1;
			next_out_upd = ~clear_busy; // see R2
		end
	end

	// registers; the device reset pin restores the power-on state
	always_ff @(posedge I_MCLK)
	begin
		if (I_SYS_RST || !lvl[`DSL_PIN_RESET]) // see R1
		begin
			state <= dac_serial_pkg::ST_IDLE;
			shift_in <= `DSL_WORD_RESET;
			shift_out <= `DSL_WORD_RESET;
			bit_cnt <= '0;
			rb_out <= 1'b0;
			rb_oe <= 1'b0;
			input_word <= `DSL_WORD_RESET;
			conv_word <= `DSL_WORD_RESET;
			conv_twos <= 1'b0;
			out_upd <= 1'b0;
			in_upd <= 1'b0;
			clear_busy <= 1'b0;
		end
		else
		begin
			state <= next_state;
			shift_in <= next_shift_in;
			shift_out <= next_shift_out;
			bit_cnt <= next_bit_cnt;
			rb_out <= next_rb_out;
			rb_oe <= next_rb_oe;
			input_word <= next_input_word;
			conv_word <= next_conv_word;
			conv_twos <= next_conv_twos;
			out_upd <= next_out_upd;
			in_upd <= next_in_upd;
			clear_busy <= next_clear_busy;
		end
	end

	// edge history is plain bookkeeping, reset only with the system
	always_ff @(posedge I_MCLK)
	begin
		if (I_SYS_RST)
		begin
			lvl_d <= `DSL_PIN_IDLE;
		end
		else
		begin
			lvl_d <= lvl;
		end
	end

	assign O_SERIAL_READBACK_OUT = rb_out;
	assign O_SERIAL_READBACK_OE = rb_oe;
	assign O_INPUT_WORD = input_word;
	assign O_CONVERTER_WORD = conv_word;
	assign O_CONVERTER_TWOS = conv_twos;
	assign O_OUTPUT_UPDATE = out_upd;
	assign O_INPUT_UPDATE = in_upd;
endmodule : dac_serial_load_control

// ==== pkg/dac_serial_defines.svh ====
`ifndef DAC_SERIAL_DEFINES_SVH
`define DAC_SERIAL_DEFINES_SVH

// serial frame length and its bit counter
`define DSL_WORD_BITS 24
`define DSL_CNT_BITS 5
`define DSL_CNT_FULL 5'h18

// pin input bundle: bit positions inside the synchroniser vector
`define DSL_PIN_COUNT 6
`define DSL_PIN_SCLK 0
`define DSL_PIN_FRAME 1
`define DSL_PIN_WRITE 2
`define DSL_PIN_LOAD 3
`define DSL_PIN_CLEAR 4
`define DSL_PIN_RESET 5

// idle pin levels: clock high, strobes and resets released
`define DSL_PIN_IDLE 6'h3b

// reset values of the held words
`define DSL_WORD_RESET 24'h000000

`endif

// ==== pkg/dac_serial_pkg.sv ====
package dac_serial_pkg;

	// frame tracking: idle between frames, shifting while the frame is open
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_FRAME = 1'b1
	} frame_state_t;

endpackage : dac_serial_pkg

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
`include "dac_serial_defines.svh"

// three-stage synchroniser per pin; the value moves on only when stages
// two and three agree, which swallows a single-cycle disagreement
module pin_sync #(
	parameter int WIDTH = `DSL_PIN_COUNT,
	parameter logic [WIDTH-1:0] IDLE = `DSL_PIN_IDLE
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1)
		begin : g_pin
			logic s1;
			logic s2;
			logic s3;
			logic lvl;
			logic next_lvl;

			// stage one feeds only stage two
			always_comb
			begin
				next_lvl = (s2 == s3) ? s3 : lvl;
			end

			always_ff @(posedge i_clk)
			begin
				if (i_rst)
				begin
					s1 <= IDLE[g];
					s2 <= IDLE[g];
					s3 <= IDLE[g];
					lvl <= IDLE[g];
				end
				else
				begin
					s1 <= i_pin[g];
					s2 <= s1;
					s3 <= s2;
					lvl <= next_lvl;
				end
			end

			assign o_level[g] = lvl;
		end
	endgenerate
endmodule : pin_sync

// ==== test/dsl_checker.sv ====
`timescale 1ns/1ps

// pin-level checks; windows allow for the cycles the pin filters take
module dsl_checker (
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire logic I_FRAME_SEL_N,
	input wire logic I_OUTPUT_LOAD_STROBE_N,
	input wire logic I_CLEAR_TO_PRESET_N,
	input wire logic I_DEVICE_RESET_N,
	input wire logic [23:0] I_CLEAR_CODE,
	input wire logic I_CODING_TWOS,
	input wire logic O_SERIAL_READBACK_OE,
	input wire logic [23:0] O_CONVERTER_WORD,
	input wire logic O_CONVERTER_TWOS,
	input wire logic O_OUTPUT_UPDATE,
	input wire logic O_INPUT_UPDATE
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);

	// preset code is held still while clear is low
	AST_PRESET_WORD: assert property ((!I_CLEAR_TO_PRESET_N)[*8] |->
		O_CONVERTER_WORD == I_CLEAR_CODE) else $error("clear word");
	AST_PRESET_TWOS: assert property ((!I_CLEAR_TO_PRESET_N)[*8] |->
		O_CONVERTER_TWOS == I_CODING_TWOS) else $error("clear coding");
	AST_PRESET_PULSE: assert property ($fell(I_CLEAR_TO_PRESET_N) |->
		##[2:7] O_OUTPUT_UPDATE) else $error("clear no update");
	AST_LOAD_FALL: assert property ($fell(I_OUTPUT_LOAD_STROBE_N) &&
		I_CLEAR_TO_PRESET_N |-> ##[2:7] O_OUTPUT_UPDATE) else $error("no load");
	AST_TIED_LOW: assert property (!I_OUTPUT_LOAD_STROBE_N[*8] ##0
		O_INPUT_UPDATE |-> O_OUTPUT_UPDATE) else $error("no update at close");
	AST_HELD_HIGH: assert property (I_OUTPUT_LOAD_STROBE_N[*8] ##0
		O_INPUT_UPDATE |-> !O_OUTPUT_UPDATE) else $error("early update");
	AST_OE_OFF: assert property (I_FRAME_SEL_N[*8] |->
		!O_SERIAL_READBACK_OE) else $error("readback still driven");
	AST_DEV_RST: assert property (!I_DEVICE_RESET_N[*8] |->
		O_CONVERTER_WORD == 24'h000000) else $error("device reset");
endmodule : dsl_checker

bind dac_serial_load_control dsl_checker i_chk (
	.I_MCLK(I_MCLK),
	.I_SYS_RST(I_SYS_RST),
	.I_FRAME_SEL_N(I_FRAME_SEL_N),
	.I_OUTPUT_LOAD_STROBE_N(I_OUTPUT_LOAD_STROBE_N),
	.I_CLEAR_TO_PRESET_N(I_CLEAR_TO_PRESET_N),
	.I_DEVICE_RESET_N(I_DEVICE_RESET_N),
	.I_CLEAR_CODE(I_CLEAR_CODE),
	.I_CODING_TWOS(I_CODING_TWOS),
	.O_SERIAL_READBACK_OE(O_SERIAL_READBACK_OE),
	.O_CONVERTER_WORD(O_CONVERTER_WORD),
	.O_CONVERTER_TWOS(O_CONVERTER_TWOS),
	.O_OUTPUT_UPDATE(O_OUTPUT_UPDATE),
	.O_INPUT_UPDATE(O_INPUT_UPDATE)
);

// ==== test/dsl_host.sv ====
`timescale 1ns/1ps

// host link end: clock idles high between frames; readback is taken
// late in the low phase, which leaves margin for the device's filters
module dsl_host (
	input wire logic i_readback,
	output logic o_sclk,
	output logic o_frame_n,
	output logic o_write
);
	initial
	begin
		o_sclk = 1'b1;
		o_frame_n = 1'b1;
		o_write = 1'b0;
	end

	// n bits of v, msb first, at a 160 ns clock
	task automatic xfer(input logic [31:0] v, input int n,
		output logic [23:0] rb);
		// called just after a clock edge, so every pin moves at that offset
		o_frame_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			o_write = v[i];
			#40 o_sclk = 1'b0;
			#80 if (i < n - 1) rb = {rb[22:0], i_readback};
			o_sclk = 1'b1;
			#40;
		end
		#120 rb = {rb[22:0], i_readback};
		o_frame_n = 1'b1;
		o_write = ~o_write; // released data line shows no stale level
	endtask : xfer
endmodule : dsl_host

// ==== test/dac_serial_load_control_tb.sv ====
`timescale 1ns/1ps

module dac_serial_load_control_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ld_n = 1'b0;
	logic preset_n = 1'b1;
	logic drst_n = 1'b1;
	logic twos = 1'b0;
	logic sclk, fs_n, wd, rbo, oe, ctw, uo, ui;
	logic [23:0] code = 24'h000000;
	logic [23:0] rbw = 24'h000000;
	logic [23:0] w, p, rb, iw, cw;
	int failures = 0;
	int compares = 0;
	// a released readback wire shows the opposite of its last level
	wire logic rbl = oe ? rbo : ~rbo;

	always #10 clk = ~clk;

	dac_serial_load_control i_dut (.I_MCLK(clk), .I_SYS_RST(rst),
		.I_SCLK(sclk), .I_FRAME_SEL_N(fs_n), .I_SERIAL_WRITE_IN(wd),
		.I_OUTPUT_LOAD_STROBE_N(ld_n), .I_CLEAR_TO_PRESET_N(preset_n),
		.I_DEVICE_RESET_N(drst_n), .I_CLEAR_CODE(code),
		.I_CODING_TWOS(twos), .I_READBACK_WORD(rbw),
		.O_SERIAL_READBACK_OUT(rbo), .O_SERIAL_READBACK_OE(oe),
		.O_INPUT_WORD(iw), .O_CONVERTER_WORD(cw), .O_CONVERTER_TWOS(ctw),
		.O_OUTPUT_UPDATE(uo), .O_INPUT_UPDATE(ui));
	dsl_host host (.i_readback(rbl), .o_sclk(sclk), .o_frame_n(fs_n),
		.o_write(wd));

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	task automatic chk(input string s, input logic [23:0] e, g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk

	// expected word of a frame: the last 24 bits shifted in
	function automatic logic [23:0] last24(input logic [31:0] v);
		return v[23:0];
	endfunction : last24

	task automatic send(input logic [31:0] v, input int n);
		host.xfer(v, n, rb);
		tick(8);
	endtask : send

	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	initial
	begin
		void'($urandom(32'he677));
		tick(16);
		rst = 1'b0;
		tick(8);
		chk("conv", 24'h000000, cw);
		for (int k = 0; k < 6; k++)
		begin
			w = k == 0 ? 24'hffffff : 24'($urandom());
			rbw = 24'($urandom());
			send({8'h00, w}, 24);
			chk("conv", last24({8'h00, w}), cw);
			chk("rb", rbw, rb);
		end
		$display("tied_low done");
		p = w;
		w = 24'($urandom());
		ld_n = 1'b1;
		send({8'h00, w}, 24);
		chk("in", w, iw);
		chk("conv", p, cw);
		ld_n = 1'b0;
		tick(8);
		chk("conv", w, cw);
		$display("held_high done");
		w = 24'($urandom());
		send({8'h03, w}, 26);
		chk("long", last24({8'h03, w}), cw);
		send(32'h000abcde, 20);
		chk("short", w, iw);
		$display("frame_len done");
		for (int t = 0; t < 2; t++)
		begin
			code = 24'($urandom());
			twos = t[0];
			preset_n = 1'b0;
			tick(10);
			chk("preset", code, cw);
			chk("twos", {23'h000000, twos}, {23'h000000, ctw});
			preset_n = 1'b1;
			tick(8);
		end
		$display("clear done");
		drst_n = 1'b0;
		tick(10);
		drst_n = 1'b1;
		tick(8);
		chk("in", 24'h000000, iw);
		$display("dev_reset done");
		wrap_up();
	end

	// tests need about 40 us; a hang is cut off well past that
	initial
	begin
		#500000;
		failures++;
		wrap_up();
	end
endmodule : dac_serial_load_control_tb
